// file: core/phr_pkg.sv
package phr_pkg;
    // =========================================================
    // widths and timing
    localparam int HITS_W = 64;
    localparam int STAMP_W = 24;
    localparam int WORD_W = HITS_W + STAMP_W;
    localparam int CLK10_PERIOD_NS = 100;
    localparam int SYS_PERIOD_NS = 4;
    localparam int PIPE_DELAY_NS = 2000;
    localparam int PIPE_DEPTH = PIPE_DELAY_NS / CLK10_PERIOD_NS;
    localparam int FIFO_DEPTH = 8;
    localparam int STRAP_W = 5;
    localparam int DAC_W = 8;
    // =========================================================
    // serial symbol: start, type, eight data bits, stop
    localparam int BYTE_W = 8;
    localparam int SYM_W = 11;
    localparam int BYTES_PER_WORD = WORD_W / BYTE_W;
    localparam int FRAME_W = SYM_W * BYTES_PER_WORD;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic SYM_START = 1'b0;
    localparam logic SYM_STOP = 1'b1;
    localparam logic TYPE_HEAD = 1'b1;
    localparam logic TYPE_BODY = 1'b0;
    // =========================================================
    // control word layout, shifted in msb first
    localparam int CTL_W = 24;
    localparam int CTL_DATA_W = 16;
    localparam int CTL_SEL_W = 3;
    localparam logic [CTL_SEL_W-1:0] SEL_CFG = 3'h0;
    localparam logic [CTL_SEL_W-1:0] SEL_DAC = 3'h1;
    localparam logic [CTL_SEL_W-1:0] SEL_INJ = 3'h2;
    localparam logic [CTL_SEL_W-1:0] SEL_MASK0 = 3'h4;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_GAIN_BIT = 2;
    localparam logic [DAC_W-1:0] DAC_RESET = 8'h80;
    localparam logic [HITS_W-1:0] MASK_RESET = {HITS_W{1'b1}};

    typedef enum logic [1:0] {
        PHR_TRIG_EXT = 2'h0,
        PHR_TRIG_INT = 2'h1,
        PHR_TRIG_GATED = 2'h3
    } phr_mode_type;

    typedef struct packed {
        logic [HITS_W-1:0] hits;
        logic [STAMP_W-1:0] stamp;
    } phr_word_type;

    typedef struct packed {
        phr_word_type word;
        logic self_hit;
        logic gate_hit;
        logic valid;
    } phr_stage_type;

    typedef struct packed {
        logic [STRAP_W-1:0] addr;
        logic [CTL_SEL_W-1:0] sel;
        logic [CTL_DATA_W-1:0] data;
    } phr_ctl_type;
endpackage

// file: core/phr_readout.sv
`timescale 1ns/10ps
`default_nettype none
module phr_readout #(
    parameter int PIPE_STAGES = phr_pkg::PIPE_DEPTH,
    parameter int FIFO_WORDS = phr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // timing pins
    input wire logic clk10_pin,
    input wire logic cnt_clr_pin,
    // discriminators
    input wire logic [phr_pkg::HITS_W-1:0] disc_pin,
    // trigger pins
    input wire logic trig_in_pin,
    input wire logic gate_in_pin,
    output logic trig_out,
    // control link and straps
    input wire logic ctl_sel_pin,
    input wire logic ctl_dat_pin,
    input wire logic [phr_pkg::STRAP_W-1:0] strap_addr,
    // analog settings
    output logic [phr_pkg::DAC_W-1:0] thr_dac,
    output logic gain_x10,
    output logic inject,
    // status
    output logic fifo_full,
    output logic drop_pulse,
    // serial data out
    output logic sdo
);
    import phr_pkg::*;

    localparam int FA_W = $clog2(FIFO_WORDS);
    localparam int SYNC_W = HITS_W + 6;

    // the shift check below looks at stage 1, so one stage is not enough
    if (PIPE_STAGES < 2) begin : g_bad_pipe
        $error("pipeline needs at least two stages");
    end
    if (FIFO_WORDS < 2 || (1 << FA_W) != FIFO_WORDS) begin : g_bad_fifo
        $error("fifo depth must be a power of two of at least two");
    end

    // =========================================================
    // pin synchronisers: three flops, change taken when 2 and 3 agree
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] lvl_reg;
    assign pins = {disc_pin, clk10_pin, cnt_clr_pin, trig_in_pin, gate_in_pin,
        ctl_sel_pin, ctl_dat_pin};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
        end
    end

    logic [HITS_W-1:0] disc_lvl;
    logic clk10_lvl;
    logic clr_lvl;
    logic trig_lvl;
    logic gate_lvl;
    logic csel_lvl;
    logic cdat_lvl;
    assign {disc_lvl, clk10_lvl, clr_lvl, trig_lvl, gate_lvl, csel_lvl, cdat_lvl} = lvl_reg;

    // rising edge of the 10 MHz clock is the only timing reference
    logic clk10_d_reg;
    logic tick;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk10_d_reg <= 1'b0;
        end else begin
            clk10_d_reg <= clk10_lvl;
        end
    end
    assign tick = clk10_lvl && !clk10_d_reg;

    // =========================================================
    // straps: captured once after reset release, they never move
    logic [STRAP_W-1:0] addr_reg;
    logic addr_ok_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_reg <= '0;
            addr_ok_reg <= 1'b0;
        end else if (!addr_ok_reg) begin
            addr_reg <= strap_addr;
            addr_ok_reg <= 1'b1;
        end
    end

    // =========================================================
    // control receiver: bits shifted on ticks while select is high
    phr_ctl_type ctl_reg;
    logic [4:0] ctl_cnt_reg;
    logic csel_d_reg;
    logic apply;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= '0;
            ctl_cnt_reg <= 5'h00;
            csel_d_reg <= 1'b0;
        end else begin
            csel_d_reg <= csel_lvl;
            if (!csel_lvl) begin
                ctl_cnt_reg <= (csel_d_reg) ? 5'h00 : ctl_cnt_reg;
            end else if (tick) begin
                ctl_reg <= {ctl_reg[CTL_W-2:0], cdat_lvl};
                if (ctl_cnt_reg != 5'(CTL_W)) begin
                    ctl_cnt_reg <= ctl_cnt_reg + 5'h01;
                end
            end
        end
    end
    // short frames are ignored, as are other chips' words; a long frame applies its last 24 bits
    assign apply = csel_d_reg && !csel_lvl && ctl_cnt_reg == 5'(CTL_W)
        && addr_ok_reg && ctl_reg.addr == addr_reg;

    phr_mode_type mode_reg;
    logic [HITS_W-1:0] mask_reg;
    logic [DAC_W-1:0] dac_reg;
    logic gain_reg;
    logic inj_arm_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= PHR_TRIG_EXT;
            mask_reg <= MASK_RESET;
            dac_reg <= DAC_RESET;
            gain_reg <= 1'b0;
        end else if (apply) begin
            case (ctl_reg.sel)
                SEL_CFG: begin
                    mode_reg <= phr_mode_type'(ctl_reg.data[CFG_MODE_LSB +: 2]);
                    gain_reg <= ctl_reg.data[CFG_GAIN_BIT];
                end
                SEL_DAC: dac_reg <= ctl_reg.data[DAC_W-1:0];
                SEL_INJ: ;
                default: begin
                    if (ctl_reg.sel >= SEL_MASK0) begin
                        mask_reg[CTL_DATA_W*(ctl_reg.sel - SEL_MASK0) +: CTL_DATA_W]
                            <= ctl_reg.data;
                    end
                end
            endcase
        end
    end

    // injection waits for the next 10 MHz edge so all chips fire together
    logic inj_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inj_arm_reg <= 1'b0;
            inj_reg <= 1'b0;
        end else begin
            inj_reg <= inj_arm_reg && tick;
            if (apply && ctl_reg.sel == SEL_INJ) begin
                inj_arm_reg <= 1'b1;
            end else if (tick) begin
                inj_arm_reg <= 1'b0;
            end
        end
    end

    // =========================================================
    // stamp counter
    logic [STAMP_W-1:0] stamp_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stamp_reg <= '0;
        end else if (tick) begin
            stamp_reg <= clr_lvl ? '0 : stamp_reg + 1'b1;
        end
    end

    // =========================================================
    // capture and pipeline
    logic [HITS_W-1:0] hits_now;
    phr_stage_type pipe_reg [PIPE_STAGES];
    phr_stage_type pipe_end;
    logic trig_out_reg;
    assign hits_now = disc_lvl & mask_reg;
    assign pipe_end = pipe_reg[PIPE_STAGES-1];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PIPE_STAGES; i++) begin
                pipe_reg[i] <= '0;
            end
            trig_out_reg <= 1'b0;
        end else if (tick) begin
            pipe_reg[0].word <= '{hits: hits_now, stamp: stamp_reg};
            pipe_reg[0].self_hit <= |hits_now;
            pipe_reg[0].gate_hit <= gate_lvl && |hits_now;
            pipe_reg[0].valid <= 1'b1;
            for (int i = 1; i < PIPE_STAGES; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
            trig_out_reg <= |hits_now;
        end
    end

    // keep decision for the word leaving the pipeline
    logic keep;
    always_comb begin
        case (mode_reg)
            PHR_TRIG_EXT: keep = trig_lvl;
            PHR_TRIG_INT: keep = pipe_end.self_hit;
            PHR_TRIG_GATED: keep = pipe_end.gate_hit;
            default: keep = 1'b0;
        endcase
    end

    // =========================================================
    // output fifo
    phr_word_type fifo_mem [FIFO_WORDS];
    logic [FA_W-1:0] wr_ptr_reg;
    logic [FA_W-1:0] rd_ptr_reg;
    logic [FA_W:0] count_reg;
    logic push_req;
    logic push;
    logic pop;
    logic full;
    logic tx_busy;
    logic drop_reg;
    logic full_reg;
    assign full = count_reg == (FA_W+1)'(FIFO_WORDS);
    assign push_req = tick && pipe_end.valid && keep;
    assign push = push_req && !full;
    assign pop = !tx_busy && count_reg != '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (FA_W+1)'(push) - (FA_W+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= pipe_end.word;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drop_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            drop_reg <= push_req && full;
            full_reg <= (count_reg + (FA_W+1)'(push) - (FA_W+1)'(pop))
                == (FA_W+1)'(FIFO_WORDS);
        end
    end

    // =========================================================
    // serial transmitter
    phr_sym_tx u_tx (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .load(pop),
        .word(fifo_mem[rd_ptr_reg]),
        .busy(tx_busy),
        .sdo(sdo)
    );

    assign trig_out = trig_out_reg;
    assign thr_dac = dac_reg;
    assign gain_x10 = gain_reg;
    assign inject = inj_reg;
    assign fifo_full = full_reg;
    assign drop_pulse = drop_reg;

    // =========================================================
    // checks
    a_stamp_clear: assert property (@(posedge sys_clk) disable iff (rst)
        tick && clr_lvl |=> stamp_reg == '0)
        else $error("stamp not cleared");
    a_stamp_count: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !clr_lvl |=> stamp_reg == $past(stamp_reg) + 1'b1)
        else $error("stamp did not advance");
    a_mask_and: assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> (pipe_reg[0].word.hits & ~$past(mask_reg)) == '0)
        else $error("masked channel captured");
    a_pipe_delay: assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> pipe_reg[1] == $past(pipe_reg[0]))
        else $error("pipeline did not shift");
    a_ext_keep: assert property (@(posedge sys_clk) disable iff (rst)
        tick && mode_reg == PHR_TRIG_EXT && pipe_end.valid && trig_lvl && !full
        |=> count_reg != '0)
        else $error("external trigger lost word");
    a_full_drop: assert property (@(posedge sys_clk) disable iff (rst)
        push_req && full |=> drop_reg && wr_ptr_reg == $past(wr_ptr_reg))
        else $error("full fifo overwritten");
    a_fifo_bound: assert property (@(posedge sys_clk) disable iff (rst)
        count_reg <= (FA_W+1)'(FIFO_WORDS))
        else $error("fifo count over depth");
    // compared against the straps themselves, not the captured copy
    a_addr_only: assert property (@(posedge sys_clk) disable iff (rst)
        ctl_reg.addr != strap_addr |=> $stable(dac_reg) && $stable(mask_reg))
        else $error("foreign control word applied");
    a_push_out: assert property (@(posedge sys_clk) disable iff (rst)
        count_reg != '0 && !tx_busy |=> tx_busy)
        else $error("stored word not sent");
    a_trig_out: assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> trig_out == |$past(hits_now))
        else $error("trigger output mismatch");

    c_int_keep: cover property (@(posedge sys_clk) disable iff (rst)
        mode_reg == PHR_TRIG_INT && push);
    c_drop: cover property (@(posedge sys_clk) disable iff (rst) drop_reg);
    c_cfg: cover property (@(posedge sys_clk) disable iff (rst)
        apply && ctl_reg.sel == SEL_CFG);
endmodule // phr_readout
`default_nettype wire

// file: core/phr_sym_tx.sv
`timescale 1ns/10ps
`default_nettype none
module phr_sym_tx (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bit timing and load
    input wire logic tick,
    input wire logic load,
    input wire phr_pkg::phr_word_type word,
    // line
    output logic busy,
    output logic sdo
);
    import phr_pkg::*;

    localparam logic [7:0] FRAME_LEN = 8'(FRAME_W);
    logic [FRAME_W-1:0] frame_reg;
    logic [FRAME_W-1:0] frame_next;
    logic [7:0] left_reg;
    logic sdo_reg;

    // =========================================================
    // frame build: byte 0 carries the header type bit
    always_comb begin
        frame_next = '0;
        for (int b = 0; b < BYTES_PER_WORD; b++) begin
            frame_next[FRAME_W-1-b*SYM_W -: SYM_W] = {SYM_START,
                (b == 0) ? TYPE_HEAD : TYPE_BODY,
                word[WORD_W-1-b*BYTE_W -: BYTE_W], SYM_STOP};
        end
    end

    // =========================================================
    // shifter: one bit per 10 MHz tick, idle level when empty
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_reg <= '0;
            left_reg <= 8'h00;
            sdo_reg <= LINE_IDLE;
        end else if (load && left_reg == 8'h00) begin
            frame_reg <= frame_next;
            left_reg <= FRAME_LEN;
        end else if (tick) begin
            if (left_reg != 8'h00) begin
                sdo_reg <= frame_reg[FRAME_W-1];
                frame_reg <= frame_reg << 1;
                left_reg <= left_reg - 8'h01;
            end else begin
                sdo_reg <= LINE_IDLE;
            end
        end
    end

    assign busy = (left_reg != 8'h00);
    assign sdo = sdo_reg;

    a_line_idle: assert property (@(posedge sys_clk) disable iff (rst)
        $past(tick) && $past(left_reg) == 8'h00 && !$past(load) |-> sdo_reg == LINE_IDLE)
        else $error("line not idle with nothing to send");
    a_frame_len: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(busy) |-> left_reg == FRAME_LEN)
        else $error("frame length wrong");
endmodule // phr_sym_tx
`default_nettype wire

// file: verification/phr_conc_model.sv
`timescale 1ns/10ps
`default_nettype none
module phr_conc_model (
    // clock
    input wire logic sys_clk,
    // timing and control lines to the chip
    output logic clk10_pin,
    output logic cnt_clr_pin,
    output logic ctl_sel_pin,
    output logic ctl_dat_pin,
    // serial data from the chip
    input wire logic sdo
);
    import phr_pkg::*;
    int ph = 0;
    int per_no = 0;
    int frame_err = 0;
    phr_word_type rx_q[$];
    int start_q[$];
    // =========================================
    // 10 mhz clock, 12 cycles high and 13 low, free running
    initial begin
        clk10_pin = 1'b0;
        cnt_clr_pin = 1'b0;
        ctl_sel_pin = 1'b0;
        ctl_dat_pin = 1'b0;
    end
    always @(posedge sys_clk) begin
        ph <= (ph == 24) ? 0 : ph + 1;
        clk10_pin <= (ph < 12);
    end
    always @(negedge clk10_pin) begin
        per_no <= per_no + 1;
    end
    // =========================================
    // control and clear, changed at the falling edge, away from the tick
    task automatic send_ctl(input phr_ctl_type w, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk10_pin);
            ctl_sel_pin <= 1'b1;
            ctl_dat_pin <= w[CTL_W-1-i]; // target address leads every word
        end
        @(negedge clk10_pin);
        ctl_sel_pin <= 1'b0;
        ctl_dat_pin <= ~ctl_dat_pin; // released line must not keep the last bit
        @(negedge clk10_pin);
    endtask
    task automatic clear_next();
        @(negedge clk10_pin);
        cnt_clr_pin <= 1'b1; // exactly one period wide, so all chips clear on one tick
        @(negedge clk10_pin);
        cnt_clr_pin <= 1'b0;
    endtask
    // =========================================
    // receiver: sampled mid period, far from the bit change after each tick
    initial begin : rx
        logic [0:FRAME_W-1] f;
        phr_word_type w;
        int t0;
        forever begin
            @(negedge clk10_pin);
            if (sdo === SYM_START) begin
                t0 = per_no;
                f[0] = sdo;
                for (int i = 1; i < FRAME_W; i++) begin
                    @(negedge clk10_pin);
                    f[i] = sdo;
                end
                for (int s = 0; s < BYTES_PER_WORD; s++) begin
                    if (f[s*SYM_W] !== SYM_START || f[s*SYM_W+SYM_W-1] !== SYM_STOP ||
                        f[s*SYM_W+1] !== ((s == 0) ? TYPE_HEAD : TYPE_BODY)) begin
                        frame_err++;
                    end
                    w = {w[WORD_W-BYTE_W-1:0], f[s*SYM_W+2 +: BYTE_W]};
                end
                rx_q.push_back(w);
                start_q.push_back(t0);
            end
        end
    end
endmodule // phr_conc_model
`default_nettype wire

// file: verification/tb_phr_readout.sv
`timescale 1ns/10ps
`default_nettype none
module tb_phr_readout;
    import phr_pkg::*;
    // short pipe keeps the run brief; all expectations use it
    localparam int PIPE = 4;
    localparam logic [STRAP_W-1:0] MY_ADDR = 5'h0b;
    localparam logic [HITS_W-1:0] BURST = 64'h00a5;
    typedef struct {
        logic [1:0] mode;
        logic [HITS_W-1:0] disc;
        logic gate;
        logic trig;
        logic [3:0] lead;
        logic keep;
    } phr_row_type;
    logic sys_clk, rst, clk10_pin, cnt_clr_pin, trig_in_pin, gate_in_pin, trig_out;
    logic ctl_sel_pin, ctl_dat_pin, gain_x10, inject, fifo_full, drop_pulse, sdo;
    logic [HITS_W-1:0] disc_pin;
    logic [STRAP_W-1:0] strap_addr;
    logic [DAC_W-1:0] thr_dac;
    logic [HITS_W-1:0] mask = MASK_RESET;
    logic [1:0] cur_mode = 2'h0;
    logic full_seen = 1'b0;
    int error_cnt = 0;
    int checks_done = 0;
    int inj_cnt = 0;
    int drop_cnt = 0;
    int n;
    phr_row_type rows[8];

    phr_readout #(.PIPE_STAGES(PIPE), .FIFO_WORDS(FIFO_DEPTH)) phr_readout_i (
        .sys_clk(sys_clk), .rst(rst), .clk10_pin(clk10_pin), .cnt_clr_pin(cnt_clr_pin),
        .disc_pin(disc_pin), .trig_in_pin(trig_in_pin), .gate_in_pin(gate_in_pin),
        .trig_out(trig_out), .ctl_sel_pin(ctl_sel_pin), .ctl_dat_pin(ctl_dat_pin),
        .strap_addr(strap_addr), .thr_dac(thr_dac), .gain_x10(gain_x10), .inject(inject),
        .fifo_full(fifo_full), .drop_pulse(drop_pulse), .sdo(sdo));
    phr_conc_model phr_conc_model_i (
        .sys_clk(sys_clk), .clk10_pin(clk10_pin), .cnt_clr_pin(cnt_clr_pin),
        .ctl_sel_pin(ctl_sel_pin), .ctl_dat_pin(ctl_dat_pin), .sdo(sdo));

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (inject === 1'b1) inj_cnt++;
        if (drop_pulse === 1'b1) drop_cnt++;
        if (fifo_full === 1'b1) full_seen = 1'b1;
    end
    // =========================================
    // helpers
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic falls(input int k);
        repeat (k) @(negedge clk10_pin);
    endtask
    task automatic ctl(input logic [CTL_SEL_W-1:0] s, input logic [CTL_DATA_W-1:0] d);
        phr_conc_model_i.send_ctl(phr_ctl_type'{MY_ADDR, s, d}, CTL_W);
    endtask
    // one event: clear, one hit period, trigger at the pipe end, then the link
    task automatic run_row(input phr_row_type r);
        phr_word_type exp;
        exp.hits = r.disc & mask;
        exp.stamp = {20'h0, r.lead} - 24'h1;
        if (r.mode !== cur_mode) begin
            ctl(SEL_CFG, {14'h0, r.mode});
            cur_mode = r.mode;
        end
        phr_conc_model_i.rx_q.delete();
        phr_conc_model_i.clear_next();
        falls(r.lead - 1);
        disc_pin <= r.disc;
        gate_in_pin <= r.gate;
        falls(1);
        disc_pin <= '0;
        gate_in_pin <= 1'b0;
        check("trig_out", trig_out, |exp.hits);
        falls(PIPE - 1);
        trig_in_pin <= r.trig;
        falls(1);
        trig_in_pin <= 1'b0;
        falls(FRAME_W + 4);
        check("kept", phr_conc_model_i.rx_q.size(), r.keep);
        if (r.keep && phr_conc_model_i.rx_q.size() > 0) begin
            check("word", phr_conc_model_i.rx_q[0], exp);
        end
    endtask
    // =========================================
    // watchdog, about half again the expected run
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    // =========================================
    // main sequence
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        disc_pin = '0;
        trig_in_pin = 1'b0;
        gate_in_pin = 1'b0;
        strap_addr = MY_ADDR;
        rows[0] = '{PHR_TRIG_EXT, 64'h8000_0000_0000_0001, 1'b0, 1'b1, 4'h1, 1'b1};
        rows[1] = '{PHR_TRIG_EXT, 64'h00f0, 1'b0, 1'b0, 4'h1, 1'b0};
        rows[2] = '{PHR_TRIG_INT, 64'h0123_4567_89ab_cdef, 1'b0, 1'b0, 4'h1, 1'b1};
        rows[3] = '{PHR_TRIG_INT, 64'h0, 1'b0, 1'b1, 4'h1, 1'b0};
        rows[4] = '{PHR_TRIG_GATED, 64'h0000_ffff_0000_0000, 1'b1, 1'b0, 4'h2, 1'b1};
        rows[5] = '{PHR_TRIG_GATED, 64'h0000_ffff_0000_0000, 1'b0, 1'b1, 4'h1, 1'b0};
        rows[6] = '{2'h2, 64'hffff, 1'b1, 1'b1, 4'h1, 1'b0};
        rows[7] = '{PHR_TRIG_EXT, 64'h0001_0000, 1'b0, 1'b1, 4'h3, 1'b1};
        repeat (15) @(posedge sys_clk);
        check("rst trig_out", trig_out, 1'b0);
        check("rst thr_dac", thr_dac, DAC_RESET);
        check("rst gain", gain_x10, 1'b0);
        check("rst inject", inject, 1'b0);
        check("rst full", fifo_full, 1'b0);
        check("rst drop", drop_pulse, 1'b0);
        check("rst sdo", sdo, LINE_IDLE);
        @(posedge sys_clk);
        rst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        foreach (rows[i]) run_row(rows[i]);
        ctl(SEL_DAC, 16'h003c);
        falls(1);
        check("dac", thr_dac, 8'h3c);
        ctl(SEL_CFG, 16'h0004);
        cur_mode = 2'h0;
        falls(1);
        check("gain", gain_x10, 1'b1);
        phr_conc_model_i.send_ctl(phr_ctl_type'{MY_ADDR ^ 5'h01, SEL_DAC, 16'h0055}, CTL_W);
        check("other addr", thr_dac, 8'h3c);
        phr_conc_model_i.send_ctl(phr_ctl_type'{MY_ADDR, SEL_DAC, 16'h0055}, CTL_W - 1);
        check("short word", thr_dac, 8'h3c);
        n = inj_cnt;
        ctl(SEL_INJ, 16'h0001);
        falls(2);
        check("inject", inj_cnt - n, 1);
        ctl(SEL_MASK0, 16'h00ff);
        ctl(SEL_MASK0 + 3'h3, 16'h0fff);
        mask = {16'h0fff, 32'hffff_ffff, 16'h00ff};
        run_row('{PHR_TRIG_INT, 64'h1000_0000_0000_0f0f, 1'b0, 1'b0, 4'h1, 1'b1});
        // burst: two more keeps than the fifo can take, last one is lost
        ctl(SEL_CFG, 16'h0000);
        cur_mode = 2'h0;
        phr_conc_model_i.rx_q.delete();
        phr_conc_model_i.start_q.delete();
        n = drop_cnt;
        phr_conc_model_i.clear_next();
        disc_pin <= BURST;
        falls(PIPE);
        trig_in_pin <= 1'b1;
        falls(FIFO_DEPTH + 2 - PIPE);
        disc_pin <= '0;
        falls(PIPE);
        trig_in_pin <= 1'b0;
        falls((FIFO_DEPTH + 1) * FRAME_W + 4);
        check("drops", drop_cnt - n, 1);
        check("full seen", full_seen, 1'b1);
        check("burst count", phr_conc_model_i.rx_q.size(), FIFO_DEPTH + 1);
        for (int i = 0; i <= FIFO_DEPTH && i < phr_conc_model_i.rx_q.size(); i++) begin
            check("burst word", phr_conc_model_i.rx_q[i], {BURST & mask, 24'(i)});
            if (i > 0) begin
                n = phr_conc_model_i.start_q[i] - phr_conc_model_i.start_q[i-1];
                check("frame spacing", n, FRAME_W);
            end
        end
        check("framing", phr_conc_model_i.frame_err, 0);
        check("full after", fifo_full, 1'b0);
        for (int i = 0; i < 4; i++) begin
            falls(1);
            check("idle", sdo, LINE_IDLE);
        end
        // mid-run reset: settings and mask return, and the path still works
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("mid rst dac", thr_dac, DAC_RESET);
        check("mid rst sdo", sdo, LINE_IDLE);
        rst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        mask = MASK_RESET;
        cur_mode = 2'h0;
        run_row(rows[0]);
        close_out();
    end
endmodule // tb_phr_readout
`default_nettype wire
